// >>> hw/ccss_pkg.sv
// Package of offsets, field positions and reset values for the clock selector
`default_nettype none
package ccss_pkg;
    localparam logic [15:0] ADDR_SUB_OSC_MODE = 16'hfff0;
    localparam logic [15:0] ADDR_CLOCK_SOURCE = 16'hfff2;
    localparam logic [15:0] ADDR_PROC_CLOCK = 16'hfffb;
    localparam logic [7:0] RST_CLOCK_SOURCE = 8'h00;
    localparam logic [7:0] RST_PROC_CLOCK = 8'h02;
    localparam logic [7:0] RST_SUB_OSC_MODE = 8'h00;
    localparam int POS_SUB_SELECT = 4;
    localparam int POS_STATUS = 5;
    localparam int POS_MAIN_DIVIDE = 1;
    localparam int POS_MAIN_STOP = 7;
    localparam int POS_FEEDBACK_OFF = 1;
    localparam int POS_SUB_STOP = 0;
    // Writable bits; all others are held at zero
    localparam logic [7:0] MASK_CLOCK_SOURCE = 8'h10;
    localparam logic [7:0] MASK_PROC_CLOCK = 8'h82;
    localparam logic [7:0] MASK_SUB_OSC_MODE = 8'h03;
    // Slow main mode divides by four; subclock path divides by two
    localparam logic [1:0] MAIN_SLOW_LAST = 2'h3;
    localparam logic SUB_DIV_LAST = 1'b1;
    localparam int SYNC_DEPTH = 3;
endpackage : ccss_pkg
`default_nettype wire

// >>> hw/ccss_top.sv
// CPU clock source selector, oscillator control and standby gating
//
// Strobed register access was decided locally.
`default_nettype none
module ccss_top
    import ccss_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regWrMask,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic mainOscClk,
    input wire logic subOscClk,
    input wire logic haltReq,
    input wire logic stopReq,
    input wire logic wakeReq,
    output logic cpuTick,
    output logic periphTick,
    output logic [7:0] periphDiv,
    output logic subTick,
    output logic mainOscEnable,
    output logic subOscEnable,
    output logic feedbackResistorOff,
    output logic haltMode,
    output logic stopMode
);
    logic [7:0] clockSource_r, clockSource_nxt;
    logic [7:0] procClock_r, procClock_nxt;
    logic [7:0] subOscMode_r, subOscMode_nxt;
    logic [7:0] rdData_r, rdData_nxt;
    logic [SYNC_DEPTH-1:0] sync_r [2], sync_nxt [2];
    logic level_r [2], level_nxt [2];
    logic mainEdge, subEdge;
    logic activeSub_r, activeSub_nxt;
    logic activeSlow_r, activeSlow_nxt;
    logic [1:0] mainCnt_r, mainCnt_nxt;
    logic subCnt_r, subCnt_nxt;
    logic [7:0] periphDiv_r, periphDiv_nxt;
    logic cpuTick_r, cpuTick_nxt;
    logic periphTick_r, periphTick_nxt;
    logic subTick_r, subTick_nxt;
    logic mainOscEn_r, mainOscEn_nxt;
    logic subOscEn_r, subOscEn_nxt;
    logic fbOff_r, fbOff_nxt;
    logic halt_r, halt_nxt;
    logic stop_r, stop_nxt;
    logic wrSrc, wrProc, wrMode;

    function automatic logic [7:0] mergeWrite(input logic [7:0] old,
                                              input logic [7:0] data,
                                              input logic [7:0] bitMask,
                                              input logic [7:0] legal);
        mergeWrite = ((old & ~bitMask) | (data & bitMask)) & legal;
    endfunction : mergeWrite

    assign wrSrc = regWr && (regAddr == ADDR_CLOCK_SOURCE);
    assign wrProc = regWr && (regAddr == ADDR_PROC_CLOCK);
    assign wrMode = regWr && (regAddr == ADDR_SUB_OSC_MODE);

    // Oscillator pins are asynchronous: three flops, then agreement filter
    for (genvar g = 0; g < 2; g++) begin : g_sync
        always_comb begin
            sync_nxt[g] = {sync_r[g][SYNC_DEPTH-2:0],
                           (g == 0) ? mainOscClk : subOscClk};
            level_nxt[g] = level_r[g];
            if (sync_r[g][1] == sync_r[g][2]) begin
                level_nxt[g] = sync_r[g][2];
            end
        end
    end
    // A stopped oscillator yields no edges even if the pin still toggles
    assign mainEdge = level_nxt[0] && !level_r[0] && mainOscEn_r;
    assign subEdge = level_nxt[1] && !level_r[1] && subOscEn_r;

    always_comb begin
        clockSource_nxt = clockSource_r;
        procClock_nxt = procClock_r;
        subOscMode_nxt = subOscMode_r;
        if (wrSrc) begin
            clockSource_nxt = mergeWrite(clockSource_r, regWrData,
                                         regWrMask, MASK_CLOCK_SOURCE);
        end
        if (wrProc) begin
            procClock_nxt = mergeWrite(procClock_r, regWrData, regWrMask,
                                       MASK_PROC_CLOCK);
            // Setting the stop bit counts only once the CPU runs on the subclock
            if (!activeSub_r && !procClock_r[POS_MAIN_STOP]) begin
                procClock_nxt[POS_MAIN_STOP] = 1'b0;
            end
        end
        if (wrMode) begin
            subOscMode_nxt = mergeWrite(subOscMode_r, regWrData, regWrMask,
                                        MASK_SUB_OSC_MODE);
        end

        rdData_nxt = 8'h00;
        if (regRd) begin
            case (regAddr)
                ADDR_CLOCK_SOURCE: begin
                    rdData_nxt = clockSource_r;
                    rdData_nxt[POS_STATUS] = activeSub_r;
                end
                ADDR_PROC_CLOCK: begin
                    rdData_nxt = procClock_r;
                end
                ADDR_SUB_OSC_MODE: begin
                    rdData_nxt = subOscMode_r;
                end
                default: begin
                    rdData_nxt = 8'h00;
                end
            endcase
        end

        // Multiplexer switches only on an edge of the incoming source
        activeSub_nxt = activeSub_r;
        activeSlow_nxt = activeSlow_r;
        mainCnt_nxt = mainCnt_r;
        subCnt_nxt = subCnt_r;
        if (clockSource_r[POS_SUB_SELECT] && !activeSub_r && subEdge) begin
            activeSub_nxt = 1'b1;
            subCnt_nxt = 1'b0;
        end else if (!clockSource_r[POS_SUB_SELECT] && activeSub_r
                     && mainEdge) begin
            activeSub_nxt = 1'b0;
            activeSlow_nxt = procClock_r[POS_MAIN_DIVIDE];
            mainCnt_nxt = 2'h0;
        end else begin
            if (mainEdge) begin
                mainCnt_nxt = mainCnt_r + 2'h1;
                if (mainCnt_r == 2'h0 || !activeSlow_r) begin
                    activeSlow_nxt = procClock_r[POS_MAIN_DIVIDE];
                    mainCnt_nxt = 2'h1;
                end else if (mainCnt_r == MAIN_SLOW_LAST) begin
                    mainCnt_nxt = 2'h0;
                end
            end
            if (subEdge) begin
                subCnt_nxt = !subCnt_r;
            end
        end

        halt_nxt = halt_r;
        stop_nxt = stop_r;
        if (wakeReq) begin
            halt_nxt = 1'b0;
            stop_nxt = 1'b0;
        end else if (stopReq && !activeSub_r) begin
            stop_nxt = 1'b1;
        end else if (haltReq) begin
            halt_nxt = 1'b1;
        end

        cpuTick_nxt = 1'b0;
        if (!halt_r && !stop_r) begin
            if (activeSub_r) begin
                cpuTick_nxt = subEdge && (subCnt_r == SUB_DIV_LAST);
            end else if (activeSlow_r) begin
                cpuTick_nxt = mainEdge && (mainCnt_r == MAIN_SLOW_LAST);
            end else begin
                cpuTick_nxt = mainEdge;
            end
        end

        periphTick_nxt = mainEdge;
        periphDiv_nxt = mainEdge ? periphDiv_r + 8'h01 : periphDiv_r;
        subTick_nxt = subEdge;

        mainOscEn_nxt = !stop_nxt
                        && !(procClock_nxt[POS_MAIN_STOP] && activeSub_nxt);
        subOscEn_nxt = !subOscMode_nxt[POS_SUB_STOP];
        fbOff_nxt = subOscMode_nxt[POS_FEEDBACK_OFF];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            clockSource_r <= RST_CLOCK_SOURCE;
            procClock_r <= RST_PROC_CLOCK;
            subOscMode_r <= RST_SUB_OSC_MODE;
            rdData_r <= 8'h00;
            sync_r[0] <= '0;
            sync_r[1] <= '0;
            level_r <= '{1'b0, 1'b0};
            activeSub_r <= 1'b0;
            activeSlow_r <= RST_PROC_CLOCK[POS_MAIN_DIVIDE];
            mainCnt_r <= 2'h0;
            subCnt_r <= 1'b0;
            periphDiv_r <= 8'h00;
            cpuTick_r <= 1'b0;
            periphTick_r <= 1'b0;
            subTick_r <= 1'b0;
            mainOscEn_r <= 1'b0;
            subOscEn_r <= 1'b1;
            fbOff_r <= 1'b0;
            halt_r <= 1'b0;
            stop_r <= 1'b0;
        end else begin
            clockSource_r <= clockSource_nxt;
            procClock_r <= procClock_nxt;
            subOscMode_r <= subOscMode_nxt;
            rdData_r <= rdData_nxt;
            sync_r[0] <= sync_nxt[0];
            sync_r[1] <= sync_nxt[1];
            level_r <= level_nxt;
            activeSub_r <= activeSub_nxt;
            activeSlow_r <= activeSlow_nxt;
            mainCnt_r <= mainCnt_nxt;
            subCnt_r <= subCnt_nxt;
            periphDiv_r <= periphDiv_nxt;
            cpuTick_r <= cpuTick_nxt;
            periphTick_r <= periphTick_nxt;
            subTick_r <= subTick_nxt;
            mainOscEn_r <= mainOscEn_nxt;
            subOscEn_r <= subOscEn_nxt;
            fbOff_r <= fbOff_nxt;
            halt_r <= halt_nxt;
            stop_r <= stop_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign cpuTick = cpuTick_r;
    assign periphTick = periphTick_r;
    assign periphDiv = periphDiv_r;
    assign subTick = subTick_r;
    assign mainOscEnable = mainOscEn_r;
    assign subOscEnable = subOscEn_r;
    assign feedbackResistorOff = fbOff_r;
    assign haltMode = halt_r;
    assign stopMode = stop_r;

    property p_reset_values;
        @(posedge clk) reset |=> clockSource_r == 8'h00
            && procClock_r == 8'h02 && subOscMode_r == 8'h00;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("register reset values wrong");

    property p_osc_off_in_reset;
        @(posedge clk) reset |=> !mainOscEnable;
    endproperty
    a_osc_off_in_reset: assert property (p_osc_off_in_reset)
        else $error("main oscillator enabled during reset");

    property p_status_read;
        @(posedge clk) disable iff (reset)
        regRd && regAddr == ADDR_CLOCK_SOURCE
            |=> regRdData[5] == $past(activeSub_r) && regRdData[3:0] == 4'h0;
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status bit read wrong");

    property p_stop_ignored;
        @(posedge clk) disable iff (reset)
        wrProc && regWrData[7] && regWrMask[7] && !activeSub_r
            && !procClock_r[7] |=> !procClock_r[7];
    endproperty
    a_stop_ignored: assert property (p_stop_ignored)
        else $error("main stop accepted on main clock");

    property p_bit_write;
        @(posedge clk) disable iff (reset)
        wrProc && regWrMask == 8'h02
            |=> procClock_r[7] == $past(procClock_r[7])
                && procClock_r[1] == $past(regWrData[1]);
    endproperty
    a_bit_write: assert property (p_bit_write)
        else $error("single bit write disturbed other bits");

    property p_no_stop_on_sub;
        @(posedge clk) disable iff (reset)
        stopReq && !wakeReq && activeSub_r && !stop_r |=> !stopMode;
    endproperty
    a_no_stop_on_sub: assert property (p_no_stop_on_sub)
        else $error("stop entered on subclock");

    property p_standby_no_tick;
        @(posedge clk) disable iff (reset)
        (haltMode || stopMode) |=> !cpuTick;
    endproperty
    a_standby_no_tick: assert property (p_standby_no_tick)
        else $error("cpu tick during standby");

    property p_switch_on_edge;
        @(posedge clk) disable iff (reset)
        $changed(activeSub_r) |-> $past(activeSub_r ? mainEdge : subEdge);
    endproperty
    a_switch_on_edge: assert property (p_switch_on_edge)
        else $error("source switched without an edge");

    property p_tick_source;
        @(posedge clk) disable iff (reset)
        cpuTick |-> $past(activeSub_r ? subEdge : mainEdge);
    endproperty
    a_tick_source: assert property (p_tick_source)
        else $error("cpu tick from wrong source");

    property p_sub_stop;
        @(posedge clk) disable iff (reset)
        wrMode && regWrMask[0] |=> subOscEnable == !$past(regWrData[0])
            && feedbackResistorOff == subOscMode_r[1];
    endproperty
    a_sub_stop: assert property (p_sub_stop)
        else $error("sub oscillator enable wrong");

    property p_periph_main;
        @(posedge clk) disable iff (reset)
        periphTick |-> $past(mainOscEnable);
    endproperty
    a_periph_main: assert property (p_periph_main)
        else $error("peripheral tick with main oscillator stopped");
endmodule : ccss_top
`default_nettype wire

// >>> verif/ccss_osc_model.sv
// Behavioural main and subclock resonators facing the clock selector
`default_nettype none
module ccss_osc_model #(
    parameter int MAIN_HALF = 100,
    parameter int SUB_HALF = 500
) (
    input wire logic mainEn,
    input wire logic subEn,
    output logic mainClk,
    output logic subClk
);
    timeunit 1ns;
    timeprecision 1ps;
    // Subclock runs far above 32 kHz so the run stays short
    initial mainClk = 1'b0;
    initial subClk = 1'b0;
    // A stopped resonator settles at ground instead of holding its swing
    always begin
        if (mainEn === 1'b1) begin
            #MAIN_HALF mainClk = ~mainClk;
        end else begin
            mainClk = 1'b0;
            @(posedge mainEn);
        end
    end
    always begin
        if (subEn === 1'b1) begin
            #SUB_HALF subClk = ~subClk;
        end else begin
            subClk = 1'b0;
            @(posedge subEn);
        end
    end
endmodule : ccss_osc_model
`default_nettype wire

// >>> verif/ccss_top_tb.sv
// Self-checking bench for the CPU clock source selector
`default_nettype none
module ccss_top_tb import ccss_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWrData = 8'h00, regWrMask = 8'h00, regRdData, periphDiv;
    logic regWr = 1'b0, regRd = 1'b0;
    logic haltReq = 1'b0, stopReq = 1'b0, wakeReq = 1'b0;
    logic mainOscClk, subOscClk, cpuTick, periphTick, subTick;
    logic mainOscEnable, subOscEnable, feedbackResistorOff, haltMode, stopMode;
    int errors = 0, check_count = 0;
    int nCpu = 0, nPer = 0, nSub = 0, dC, dP, dS;
    integer seed = 32'h414d045b;
    always #20 clk = ~clk;
    always @(posedge clk) begin
        nCpu <= nCpu + int'(cpuTick === 1'b1);
        nPer <= nPer + int'(periphTick === 1'b1);
        nSub <= nSub + int'(subTick === 1'b1);
    end
    ccss_top u_dut (.clk(clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrMask(regWrMask), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .mainOscClk(mainOscClk),
        .subOscClk(subOscClk), .haltReq(haltReq), .stopReq(stopReq),
        .wakeReq(wakeReq), .cpuTick(cpuTick), .periphTick(periphTick),
        .periphDiv(periphDiv), .subTick(subTick),
        .mainOscEnable(mainOscEnable), .subOscEnable(subOscEnable),
        .feedbackResistorOff(feedbackResistorOff), .haltMode(haltMode),
        .stopMode(stopMode));
    ccss_osc_model u_osc (.mainEn(mainOscEnable), .subEn(subOscEnable),
        .mainClk(mainOscClk), .subClk(subOscClk));
    task automatic end_sim;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
                      input logic [7:0] m);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        regWrMask <= m;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(regRdData, exp);
    endtask : rdchk
    task automatic pulse(input int k);
        @(posedge clk);
        haltReq <= (k == 0);
        stopReq <= (k == 1);
        wakeReq <= (k == 2);
        @(posedge clk);
        haltReq <= 1'b0;
        stopReq <= 1'b0;
        wakeReq <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : pulse
    // Lets a new setting settle before counting ticks of all three kinds
    task automatic span(input int n);
        int c0, p0, s0;
        repeat (50) @(posedge clk);
        c0 = nCpu;
        p0 = nPer;
        s0 = nSub;
        repeat (n) @(posedge clk);
        dC = nCpu - c0;
        dP = nPer - p0;
        dS = nSub - s0;
    endtask : span
    function automatic logic [7:0] near(int a, int b, int tol);
        return {7'h00, (a - b <= tol) && (b - a <= tol)};
    endfunction : near
    initial begin
        logic [7:0] v, m, img;
        repeat (10) @(posedge clk);
        #1 chk({7'h00, mainOscEnable}, 8'h00);
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rdchk(ADDR_CLOCK_SOURCE, 8'h00);
        rdchk(ADDR_PROC_CLOCK, 8'h02);
        rdchk(ADDR_SUB_OSC_MODE, 8'h00);
        wr(16'hfff1, 8'hff, 8'hff);
        rdchk(16'hfff1, 8'h00);
        img = 8'h00;
        for (int i = 0; i < 12; i++) begin
            v = 8'($random(seed)) & MASK_SUB_OSC_MODE;
            m = (i % 2 == 1) ? 8'hff : 8'h01 << ((i / 2) % 2);
            wr(ADDR_SUB_OSC_MODE, v, m);
            img = (img & ~m) | (v & m);
            rdchk(ADDR_SUB_OSC_MODE, img);
            chk({7'h00, subOscEnable}, {7'h00, ~img[0]});
            chk({7'h00, feedbackResistorOff}, {7'h00, img[1]});
        end
        wr(ADDR_SUB_OSC_MODE, 8'h00, 8'hff);
        wr(ADDR_PROC_CLOCK, 8'h00, 8'hff);
        span(1000);
        chk(near(dC, dP, 2), 8'h01);
        #1 chk(periphDiv, 8'(nPer + int'(periphTick === 1'b1)));
        wr(ADDR_PROC_CLOCK, 8'h02, 8'h02);
        span(1000);
        chk(near(dC * 4, dP, 5), 8'h01);
        wr(ADDR_PROC_CLOCK, 8'h80, 8'h80);
        rdchk(ADDR_PROC_CLOCK, 8'h02);
        chk({7'h00, mainOscEnable}, 8'h01);
        pulse(0);
        chk({7'h00, haltMode}, 8'h01);
        span(200);
        chk(8'(dC), 8'h00);
        pulse(2);
        pulse(1);
        chk({6'h00, stopMode, mainOscEnable}, 8'h02);
        span(400);
        chk(8'(dP), 8'h00);
        chk({7'h00, dS > 10}, 8'h01);
        pulse(2);
        chk({6'h00, stopMode, haltMode}, 8'h00);
        // Write just after a sub edge so the next one is far off
        @(posedge clk iff subTick === 1'b1);
        wr(ADDR_CLOCK_SOURCE, 8'h10, 8'h10);
        rdchk(ADDR_CLOCK_SOURCE, 8'h10);
        repeat (60) @(posedge clk);
        rdchk(ADDR_CLOCK_SOURCE, 8'h30);
        wr(ADDR_CLOCK_SOURCE, 8'h00, 8'h20);
        rdchk(ADDR_CLOCK_SOURCE, 8'h30);
        span(1000);
        chk(near(dC * 2, dS, 3), 8'h01);
        pulse(1);
        chk({7'h00, stopMode}, 8'h00);
        pulse(0);
        chk({7'h00, haltMode}, 8'h01);
        pulse(2);
        wr(ADDR_PROC_CLOCK, 8'h80, 8'h80);
        rdchk(ADDR_PROC_CLOCK, 8'h82);
        chk({7'h00, mainOscEnable}, 8'h00);
        span(400);
        chk(8'(dP), 8'h00);
        chk({7'h00, dS > 10}, 8'h01);
        wr(ADDR_PROC_CLOCK, 8'h00, 8'h80);
        wr(ADDR_CLOCK_SOURCE, 8'h00, 8'h10);
        repeat (100) @(posedge clk);
        rdchk(ADDR_CLOCK_SOURCE, 8'h00);
        end_sim();
    end
    initial begin
        #800000;
        errors++;
        end_sim();
    end
endmodule : ccss_top_tb
`default_nettype wire
